//--- rtl/asas_map.svh
// asas_map.svh: command byte codes, field positions, reset values and timing counts
`ifndef ASAS_MAP_SVH
`define ASAS_MAP_SVH
`define ASAS_AVG_SEL_MASK    8'hE0
`define ASAS_AVG_SEL_CODE    8'h20
`define ASAS_RST_SEL_MASK    8'hF0
`define ASAS_RST_SEL_CODE    8'h10
`define ASAS_SETUP_SEL_MASK  8'hC0
`define ASAS_SETUP_SEL_CODE  8'h40
`define ASAS_AVG_FIELD_HI    4
`define ASAS_AVG_FIELD_LO    0
`define ASAS_RST_FIFO_BIT    3
`define ASAS_CKSEL_HI        5
`define ASAS_CKSEL_LO        4
`define ASAS_AVG_RESET       5'h00
`define ASAS_MODE_RESET      2'h2
`define ASAS_CONV_RESET      11'h000
`define ASAS_SCAN_REPEAT     2'h2
`define ASAS_AVG_SHIFT_BASE  3'h2
`define ASAS_REP_STEP        5'h04
`define ASAS_CLK_NS          25
`define ASAS_ACQ_NS          1400
`define ASAS_ACQ_CYC         ((`ASAS_ACQ_NS + `ASAS_CLK_NS - 1) / `ASAS_CLK_NS)
`define ASAS_REF_WAKE_US     65
`define ASAS_REF_WAKE_CYC    ((`ASAS_REF_WAKE_US * 1000 + `ASAS_CLK_NS - 1) / `ASAS_CLK_NS)
`define ASAS_FIFO_DEPTH      16
`define ASAS_FIFO_AW         4
`define ASAS_RES_W           12
`endif

//--- rtl/asas_pkg.sv
// asas_pkg: types shared by the scan and average sequencer
package asas_pkg;
    // clock mode encoding of the setup field
    typedef enum logic [1:0] {
        ASAS_CK_CNV_INT = 2'h0,
        ASAS_CK_CNV_ACQ = 2'h1,
        ASAS_CK_SER_INT = 2'h2,
        ASAS_CK_SER_EXT = 2'h3
    } asas_clkmode_e;
    // sequencer states
    typedef enum logic [2:0] {
        ASAS_IDLE, ASAS_ARMED, ASAS_TRACK, ASAS_WAKE, ASAS_CONV
    } asas_state_e;
    // averaging control fields
    typedef struct packed {
        logic       en;
        logic [1:0] navg;
        logic [1:0] nscan;
    } asas_avg_s;
    // conversion request captured from the conversion register
    typedef struct packed {
        logic [3:0] first;
        logic [3:0] last;
        logic [1:0] scan;
        logic       temp;
    } asas_conv_s;
endpackage : asas_pkg

//--- rtl/asas_fifo.sv
// asas_fifo: result memory with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "asas_map.svh"
module asas_fifo (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic                     clear,
    input  wire logic                     wrEn,
    input  wire logic [`ASAS_RES_W-1:0]   wrData,
    input  wire logic                     rdEn,
    output var  logic [`ASAS_RES_W-1:0]   rdData,
    output logic                          empty,
    output logic                          full
);
    // ***************************************
    // storage and pointers
    // ***************************************
    logic [`ASAS_RES_W-1:0]  mem [`ASAS_FIFO_DEPTH];  // result words
    logic [`ASAS_FIFO_AW:0]  wrPtr_r;                 // extra bit tells full from empty
    logic [`ASAS_FIFO_AW:0]  rdPtr_r;
    wire                     doWr = wrEn && !full;    // overflow words are dropped
    wire                     doRd = rdEn && !empty;

    assign empty = (wrPtr_r == rdPtr_r);
    assign full  = (wrPtr_r[`ASAS_FIFO_AW-1:0] == rdPtr_r[`ASAS_FIFO_AW-1:0]) &&
                   (wrPtr_r[`ASAS_FIFO_AW] != rdPtr_r[`ASAS_FIFO_AW]);

    // memory array has no reset, so it maps to plain storage
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_r[`ASAS_FIFO_AW-1:0]] <= wrData;
        end
    end

    // pointers; clear wins over both ports
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else if (clear) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            wrPtr_r <= doWr ? wrPtr_r + 1'b1 : wrPtr_r;
            rdPtr_r <= doRd ? rdPtr_r + 1'b1 : rdPtr_r;
        end
    end

    // read word lands one cycle after the read strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData <= '0;
        end else if (doRd) begin
            rdData <= mem[rdPtr_r[`ASAS_FIFO_AW-1:0]];
        end
    end
endmodule : asas_fifo
`default_nettype wire

//--- rtl/asas_sequencer.sv
// asas_sequencer: command decode, scan, averaging and end-of-conversion control
// What this block does
// - byte 001xxxxx writes the averaging register
// - averaging bit four enables result averaging
// - count code selects 4, 8, 16, 32 conversions
// - averaging off gives one conversion per result
// - repeat scan returns 4, 8, 12, 16 results
// - byte 0001xxxx writes the reset register
// - bit three low resets all, high clears results
// - low three reset bits are ignored
// - mode 00 start pulse runs whole scan
// - end flag low until select or start falls
// - temperature result stored before channel results
// - mode 01 falling start wakes and tracks
// - mode 01 temperature request times reference wake internally
// - mode 01 rising start converts, then flags end
// - mode 01 averaging counts pulses, then advances
// - mode 01 temperature runs on first rising
// - mode 10 conversion write runs whole scan
// - mode 10 end flag held until select
// - setup bits five and four pick clock mode
`timescale 1ns/10ps
`default_nettype none
`include "asas_map.svh"
module asas_sequencer (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic                     convert_start_n,   // start pin, asynchronous
    input  wire logic                     chipSelectN,       // serial select pin, asynchronous
    input  wire logic                     cmdValid,          // one-cycle command byte strobe
    input  wire logic [7:0]               cmdByte,
    input  wire logic                     convWrite,         // conversion register written
    input  wire asas_pkg::asas_conv_s     convReq,
    output logic                          adcStart,          // one-cycle converter kick
    output logic                          adcTemp,
    output logic [3:0]                    adcChannel,
    input  wire logic                     adcDone,
    input  wire logic [`ASAS_RES_W-1:0]   adcData,
    input  wire logic                     fifoRead,
    output logic [`ASAS_RES_W-1:0]        fifoData,
    output logic                          fifoEmpty,
    output logic                          endOfConvN,
    output logic [1:0]                    clockMode,
    output logic                          busy
);
    // ***************************************
    // pin synchronisers and edges
    // ***************************************
    logic cnvS1_r, cnvS2_r, cnvS3_r;   // start pin chain, idles high
    logic csS1_r, csS2_r, csS3_r;      // select pin chain, idles high

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {cnvS1_r, cnvS2_r, cnvS3_r} <= 3'h7;
            {csS1_r, csS2_r, csS3_r}    <= 3'h7;
        end else begin
            {cnvS1_r, cnvS2_r, cnvS3_r} <= {convert_start_n, cnvS1_r, cnvS2_r};
            {csS1_r, csS2_r, csS3_r}    <= {chipSelectN, csS1_r, csS2_r};
        end
    end

    wire cnvFall = cnvS3_r && !cnvS2_r;   // edges look at stage two and three only
    wire cnvRise = !cnvS3_r && cnvS2_r;
    wire csFall  = csS3_r && !csS2_r;

    // ***************************************
    // command byte decode
    // ***************************************
    wire isAvg   = cmdValid && ((cmdByte & `ASAS_AVG_SEL_MASK) == `ASAS_AVG_SEL_CODE);
    wire isRst   = cmdValid && ((cmdByte & `ASAS_RST_SEL_MASK) == `ASAS_RST_SEL_CODE);
    wire isSetup = cmdValid &&
                   ((cmdByte & `ASAS_SETUP_SEL_MASK) == `ASAS_SETUP_SEL_CODE);
    // bits below the fifo-only bit are never looked at
    wire softRst = isRst && !cmdByte[`ASAS_RST_FIFO_BIT];
    wire fifoClr = isRst;                                   // both flavours empty the fifo

    // ***************************************
    // control registers
    // ***************************************
    asas_pkg::asas_avg_s  avgReg_r;   // averaging control
    asas_pkg::asas_conv_s conv_r;     // last conversion request
    logic [1:0]           mode_r;     // clock mode, powers up in 10

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            avgReg_r <= `ASAS_AVG_RESET;
            mode_r   <= `ASAS_MODE_RESET;
            conv_r   <= `ASAS_CONV_RESET;
        end else if (softRst) begin
            avgReg_r <= `ASAS_AVG_RESET;
            mode_r   <= `ASAS_MODE_RESET;
            conv_r   <= `ASAS_CONV_RESET;
        end else begin
            if (isAvg) begin
                avgReg_r <= cmdByte[`ASAS_AVG_FIELD_HI:`ASAS_AVG_FIELD_LO];
            end
            if (isSetup) begin
                mode_r <= cmdByte[`ASAS_CKSEL_HI:`ASAS_CKSEL_LO];
            end
            if (convWrite) begin
                conv_r <= convReq;
            end
        end
    end

    // ***************************************
    // derived counts
    // ***************************************
    wire modeCnvInt = (mode_r == asas_pkg::ASAS_CK_CNV_INT);
    wire modeCnvAcq = (mode_r == asas_pkg::ASAS_CK_CNV_ACQ);
    wire modeSerInt = (mode_r == asas_pkg::ASAS_CK_SER_INT);
    // shift doubles as the divider: averages are powers of two
    wire [2:0] avgShift  = avgReg_r.en ?
                           ({1'b0, avgReg_r.navg} + `ASAS_AVG_SHIFT_BASE) : 3'h0;
    wire [5:0] avgTarget = 6'h01 << avgShift;
    wire [4:0] repTotal  = 5'(({3'h0, avgReg_r.nscan} + 5'h01) * `ASAS_REP_STEP);

    // ***************************************
    // sequencer state
    // ***************************************
    asas_pkg::asas_state_e state_r, state_nxt;
    logic [3:0]  chan_r, chan_nxt;            // channel under conversion
    logic        tempPend_r, tempPend_nxt;    // temperature still owed
    logic [4:0]  repLeft_r, repLeft_nxt;      // repeat results still owed
    logic [5:0]  avgLeft_r, avgLeft_nxt;      // conversions left in this result
    logic [16:0] sum_r, sum_nxt;              // wide enough for 32 words of 12 bits
    logic [11:0] wait_r, wait_nxt;            // wake and acquire timer
    logic        eocN_r, eocN_nxt;
    logic        start_r, start_nxt;
    logic        push_r, push_nxt;
    logic [`ASAS_RES_W-1:0] pushData_r, pushData_nxt;

    wire [16:0] newSum   = sum_r + {5'h00, adcData};
    wire        lastConv = (avgLeft_r == 6'h01);
    // temperature always goes first, so it never ends a scan
    wire        lastRes  = !tempPend_r &&
                           ((conv_r.scan == `ASAS_SCAN_REPEAT) ?
                            (repLeft_r == 5'h01) : (chan_r == conv_r.last));
    wire        scanGo   = (state_r == asas_pkg::ASAS_IDLE) &&
                           ((modeCnvInt && cnvRise) || (modeSerInt && convWrite));
    wire        armGo    = (state_r == asas_pkg::ASAS_IDLE) && modeCnvAcq && convWrite;
    // a start pin fall releases the flag in every mode except 10
    wire        eocRel   = csFall || (!modeSerInt && cnvFall);

    // next-state logic
    always_comb begin
        state_nxt    = state_r;
        chan_nxt     = chan_r;
        tempPend_nxt = tempPend_r;
        repLeft_nxt  = repLeft_r;
        avgLeft_nxt  = avgLeft_r;
        sum_nxt      = sum_r;
        wait_nxt     = wait_r;
        start_nxt    = 1'b0;
        push_nxt     = 1'b0;
        pushData_nxt = pushData_r;
        eocN_nxt     = eocRel ? 1'b1 : eocN_r;
        case (state_r)
            asas_pkg::ASAS_IDLE: begin
                // modes 10 and 01 take the request straight from the port, the copy lands too late
                if (scanGo || armGo) begin
                    chan_nxt     = modeSerInt ? convReq.first : conv_r.first;
                    tempPend_nxt = modeSerInt ? convReq.temp : conv_r.temp;
                    repLeft_nxt  = repTotal;
                    avgLeft_nxt  = avgTarget;
                    sum_nxt      = '0;
                    wait_nxt     = 12'(`ASAS_ACQ_CYC);
                    state_nxt    = scanGo ? asas_pkg::ASAS_WAKE : asas_pkg::ASAS_ARMED;
                end
                if (armGo) begin
                    chan_nxt     = convReq.first;
                    tempPend_nxt = convReq.temp;
                end
            end
            asas_pkg::ASAS_ARMED: begin
                if (cnvFall) begin
                    state_nxt = asas_pkg::ASAS_TRACK;
                end
            end
            asas_pkg::ASAS_TRACK: begin
                // host times acquisition; temperature gets the reference wait here
                if (cnvRise && tempPend_r) begin
                    wait_nxt  = 12'(`ASAS_REF_WAKE_CYC);
                    state_nxt = asas_pkg::ASAS_WAKE;
                end else if (cnvRise) begin
                    start_nxt = 1'b1;
                    state_nxt = asas_pkg::ASAS_CONV;
                end
            end
            asas_pkg::ASAS_WAKE: begin
                wait_nxt = wait_r - 12'h001;
                if (wait_r <= 12'h001) begin
                    start_nxt = 1'b1;
                    state_nxt = asas_pkg::ASAS_CONV;
                end
            end
            asas_pkg::ASAS_CONV: begin
                if (adcDone && !lastConv) begin
                    sum_nxt     = newSum;
                    avgLeft_nxt = avgLeft_r - 6'h01;
                    if (modeCnvAcq) begin
                        eocN_nxt  = 1'b0;
                        state_nxt = asas_pkg::ASAS_ARMED;
                    end else begin
                        start_nxt = 1'b1;
                    end
                end else if (adcDone) begin
                    push_nxt     = 1'b1;
                    pushData_nxt = `ASAS_RES_W'(newSum >> avgShift);
                    sum_nxt      = '0;
                    avgLeft_nxt  = avgTarget;
                    // advance: temperature, then repeats or next channel
                    if (tempPend_r) begin
                        tempPend_nxt = 1'b0;
                    end else if (conv_r.scan == `ASAS_SCAN_REPEAT) begin
                        repLeft_nxt = repLeft_r - 5'h01;
                    end else begin
                        chan_nxt = chan_r + 4'h1;
                    end
                    if (lastRes) begin
                        eocN_nxt  = 1'b0;
                        state_nxt = asas_pkg::ASAS_IDLE;
                    end else if (modeCnvAcq) begin
                        eocN_nxt  = 1'b0;
                        state_nxt = asas_pkg::ASAS_ARMED;
                    end else begin
                        start_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = asas_pkg::ASAS_IDLE;
            end
        endcase
        // a full reset aborts any scan in flight
        if (softRst) begin
            state_nxt = asas_pkg::ASAS_IDLE;
            eocN_nxt  = 1'b1;
            start_nxt = 1'b0;
            push_nxt  = 1'b0;
        end
    end

    // state registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r    <= asas_pkg::ASAS_IDLE;
            chan_r     <= '0;
            tempPend_r <= 1'b0;
            repLeft_r  <= '0;
            avgLeft_r  <= '0;
            sum_r      <= '0;
            wait_r     <= '0;
            eocN_r     <= 1'b1;
            start_r    <= 1'b0;
            push_r     <= 1'b0;
            pushData_r <= '0;
        end else begin
            state_r    <= state_nxt;
            chan_r     <= chan_nxt;
            tempPend_r <= tempPend_nxt;
            repLeft_r  <= repLeft_nxt;
            avgLeft_r  <= avgLeft_nxt;
            sum_r      <= sum_nxt;
            wait_r     <= wait_nxt;
            eocN_r     <= eocN_nxt;
            start_r    <= start_nxt;
            push_r     <= push_nxt;
            pushData_r <= pushData_nxt;
        end
    end

    // ***************************************
    // result fifo and outputs
    // ***************************************
    asas_fifo u_fifo (
        .clk    (clk),
        .reset  (reset),
        .clear  (fifoClr),
        .wrEn   (push_r),
        .wrData (pushData_r),
        .rdEn   (fifoRead),
        .rdData (fifoData),
        .empty  (fifoEmpty),
        .full   ()
    );

    assign adcStart   = start_r;
    assign adcTemp    = tempPend_r;
    assign adcChannel = chan_r;
    assign endOfConvN = eocN_r;
    assign clockMode  = mode_r;
    assign busy       = (state_r != asas_pkg::ASAS_IDLE);

    // ***************************************
    // checks
    // ***************************************
    logic [6:0] convCnt_r;   // converter answers since the last stored result
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            convCnt_r <= '0;
        end else if (push_r || softRst) begin
            convCnt_r <= '0;
        end else if (adcDone && state_r == asas_pkg::ASAS_CONV) begin
            convCnt_r <= convCnt_r + 7'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_avg_decode: assert property (isAvg |=>
                                   avgReg_r == $past(cmdByte[`ASAS_AVG_FIELD_HI:`ASAS_AVG_FIELD_LO]))
        else $error("averaging byte not stored");
    a_avg_count: assert property (push_r |-> convCnt_r == {1'b0, avgTarget})
        else $error("stored result used wrong conversion count");
    // a full reset in the same cycle legally swallows the push
    a_avg_single: assert property (!avgReg_r.en && adcDone && !softRst
                                   && state_r == asas_pkg::ASAS_CONV |=> push_r)
        else $error("averaging off but no result stored");
    a_rst_fifo: assert property (isRst && cmdByte[`ASAS_RST_FIFO_BIT]
                                 |=> fifoEmpty && $stable(avgReg_r))
        else $error("fifo-only reset misbehaved");
    a_rst_all: assert property (softRst |=> endOfConvN
                                && avgReg_r == `ASAS_AVG_RESET && mode_r == `ASAS_MODE_RESET)
        else $error("full reset left state behind");
    a_mode_select: assert property (isSetup && !isRst |=>
                                    mode_r == $past(cmdByte[`ASAS_CKSEL_HI:`ASAS_CKSEL_LO]))
        else $error("clock mode not taken");
    a_eoc_hold: assert property (!endOfConvN && !csFall && !(cnvFall && !modeSerInt)
                                 && !softRst |=> !endOfConvN)
        else $error("end flag released early");
    a_eoc_release: assert property (csFall && state_r == asas_pkg::ASAS_IDLE |=> endOfConvN)
        else $error("end flag not released by select");
    a_ser_start: assert property (modeSerInt && convWrite && !softRst
                                  && state_r == asas_pkg::ASAS_IDLE
                                  |-> ##[1:60] adcStart)
        else $error("serial start did not convert");
    a_acq_conv: assert property (modeCnvAcq && state_r == asas_pkg::ASAS_TRACK
                                 && cnvRise && !tempPend_r && !softRst |=> adcStart)
        else $error("rising start did not convert");

    c_scan_pin: cover property (modeCnvInt && state_r == asas_pkg::ASAS_CONV ##1 $fell(endOfConvN));
    c_acq_avg: cover property (modeCnvAcq && avgReg_r.en && push_r);
    c_repeat: cover property (conv_r.scan == `ASAS_SCAN_REPEAT && push_r && repLeft_r == 5'h01);
    c_temp_first: cover property (push_r && $past(tempPend_r) && !tempPend_r);
endmodule : asas_sequencer
`default_nettype wire

//--- dv/asas_adc_model.sv
// asas_adc_model: converter stand-in that answers each kick after a fixed delay
`timescale 1ns/10ps
`default_nettype none
module asas_adc_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        adcStart,
    input  wire logic        adcTemp,
    input  wire logic [3:0]  adcChannel,
    output logic             adcDone,
    output logic [11:0]      adcData
);
    logic [3:0] waitCnt; // cycles left in a conversion
    logic       odd;     // alternates results so a missing average shows
    // one-cycle done pulse; data only meaningful in that cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            waitCnt <= 4'h0;
            odd <= 1'b0;
            adcDone <= 1'b0;
            adcData <= 12'hFFF;
        end else begin
            adcDone <= (waitCnt == 4'h1);
            if (adcStart) waitCnt <= 4'hA;
            else if (waitCnt != 4'h0) waitCnt <= waitCnt - 4'h1;
            if (waitCnt == 4'h1) begin
                adcData <= (adcTemp ? 12'h800 : {4'h0, adcChannel, 4'h0}) + {10'h0, odd, 1'b0};
                odd <= ~odd;
            end else adcData <= ~adcData; // never hold a stale result
        end
    end
endmodule : asas_adc_model
`default_nettype wire

//--- dv/adc_scan_average_sequencer_test.sv
// adc_scan_average_sequencer_test: self-checking bench of the sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_scan_average_sequencer_test;
    typedef struct packed {
        logic [7:0] avg;
        logic [3:0] first;
        logic [3:0] last;
        logic [1:0] scan;
        logic       tmp;
        logic [4:0] n;
    } asas_row_s;
    logic clk, reset, startN, csN, cmdValid, convWrite, fifoRead, adcStart, adcTemp, adcDone;
    logic [7:0]  cmdByte;
    logic [3:0]  adcChannel;
    logic [11:0] adcData, fifoData;
    logic        fifoEmpty, endOfConvN, busy;
    logic [1:0]  clockMode;
    asas_pkg::asas_conv_s convReq;
    int mismatches = 0, cmp_count = 0, cycles = 0, r, k;
    asas_row_s rows [5] = '{'{8'h20, 4'h3, 4'h4, 2'h0, 1'b0, 5'd2},
        '{8'h30, 4'h2, 4'h2, 2'h0, 1'b1, 5'd2}, '{8'h3C, 4'h5, 4'h5, 2'h0, 1'b0, 5'd1},
        '{8'h23, 4'h6, 4'h6, 2'h2, 1'b0, 5'd16}, '{8'h38, 4'h7, 4'h7, 2'h2, 1'b0, 5'd4}};
    asas_sequencer dut_u (.clk(clk), .reset(reset), .convert_start_n(startN),
        .chipSelectN(csN), .cmdValid(cmdValid), .cmdByte(cmdByte), .convWrite(convWrite),
        .convReq(convReq), .adcStart(adcStart), .adcTemp(adcTemp), .adcChannel(adcChannel),
        .adcDone(adcDone), .adcData(adcData), .fifoRead(fifoRead), .fifoData(fifoData),
        .fifoEmpty(fifoEmpty), .endOfConvN(endOfConvN), .clockMode(clockMode), .busy(busy));
    asas_adc_model adc_u (.clk(clk), .reset(reset), .adcStart(adcStart), .adcTemp(adcTemp),
        .adcChannel(adcChannel), .adcDone(adcDone), .adcData(adcData));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard: far above the longest scan sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            summarize();
        end
    end
    // expected word: averaged words sit mid-way between alternating samples
    function automatic logic [11:0] expWord(input asas_row_s w, input int i);
        logic [3:0] ch;
        ch = (w.scan == 2'h2) ? w.first : w.first + 4'(i - int'(w.tmp));
        if (w.tmp && i == 0) return w.avg[4] ? 12'h801 : 12'h800;
        return {4'h0, ch, 4'h0} + (w.avg[4] ? 12'h1 : (i % 2 == 1 ? 12'h2 : 12'h0));
    endfunction : expWord
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize();
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic rst();
        reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
    endtask : rst
    task automatic cmd(input logic [7:0] b);
        cmdValid = 1'b1;
        cmdByte = b;
        @(negedge clk);
        cmdValid = 1'b0;
        repeat (2) @(negedge clk);
    endtask : cmd
    task automatic conv(input asas_row_s w);
        convWrite = 1'b1;
        convReq = {w.first, w.last, w.scan, w.tmp};
        @(negedge clk);
        convWrite = 1'b0;
        @(negedge clk);
    endtask : conv
    task automatic waitEoc();
        for (int i = 0; i < 3000 && endOfConvN !== 1'b0; i++) @(negedge clk);
        chk(endOfConvN, 1'b0);
        // the last word reaches the fifo one edge after the flag falls
        @(negedge clk);
    endtask : waitEoc
    task automatic pop(input logic [11:0] exp);
        fifoRead = 1'b1;
        @(negedge clk);
        fifoRead = 1'b0;
        @(negedge clk);
        chk(fifoData, exp);
    endtask : pop
    // pin pulse low for n cycles, then time for the synchroniser
    task automatic pulse(input logic cs, input int n);
        if (cs) csN = 1'b0;
        else startN = 1'b0;
        repeat (n) @(negedge clk);
        csN = 1'b1;
        startN = 1'b1;
        repeat (5) @(negedge clk);
    endtask : pulse
    initial begin
        {reset, startN, csN, cmdValid, convWrite, fifoRead} = 6'b111000;
        cmdByte = 8'h00;
        convReq = '0;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        chk(clockMode, 2'h2);
        chk({endOfConvN, fifoEmpty, busy}, 3'b110);
        // ************************************
        // table rows: mode 10 scans
        // ************************************
        for (r = 0; r < 5; r++) begin
            rst();
            cmd(rows[r].avg);
            conv(rows[r]);
            waitEoc();
            for (k = 0; k < rows[r].n; k++) pop(expWord(rows[r], k));
            chk({fifoEmpty, endOfConvN}, 2'b10);
            pulse(1'b1, 2);
            chk(endOfConvN, 1'b1);
        end
        // ************************************
        // soft reset: fifo only, then all
        // ************************************
        rst();
        cmd(8'h20);
        conv(rows[0]);
        waitEoc();
        cmd(8'h40);
        chk(clockMode, 2'h0);
        cmd(8'h1F);
        chk({endOfConvN, fifoEmpty, clockMode}, 4'b0100);
        cmd(8'h17);
        chk({endOfConvN, clockMode}, 3'b110);
        // mode 00: start pulse runs the scan, start fall releases the flag
        rst();
        cmd(8'h40);
        cmd(8'h20);
        conv(rows[0]);
        pulse(1'b0, 2);
        waitEoc();
        pop(12'h030);
        pop(12'h042);
        pulse(1'b0, 2);
        chk({endOfConvN, busy}, 2'b11);
        // mode 01: four start pulses make one averaged word
        rst();
        cmd(8'h50);
        cmd(8'h30);
        conv('{8'h30, 4'h1, 4'h2, 2'h0, 1'b0, 5'd1});
        // no temperature requested here, so no reference wake wait is owed
        for (k = 0; k < 4; k++) begin
            pulse(1'b0, 60);
            waitEoc();
            if (k < 3) chk(fifoEmpty, 1'b1);
        end
        pop(12'h011);
        // mode 01 temperature: short pulse, reference wait timed inside
        rst();
        cmd(8'h50);
        conv('{8'h20, 4'h4, 4'h4, 2'h0, 1'b1, 5'd2});
        pulse(1'b0, 2);
        waitEoc();
        pop(12'h800);
        pulse(1'b0, 60);
        waitEoc();
        pop(12'h042);
        chk({fifoEmpty, busy}, 2'b10);
        summarize();
    end
endmodule : adc_scan_average_sequencer_test
`default_nettype wire
